/* File: fps_params.svh */
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// register byte offsets
`define FPS_OFF_CMD     8'h00
`define FPS_OFF_STATUS  8'h04
`define FPS_OFF_CTRL    8'h08
`define FPS_GPR_BASE    2'b01
`define FPS_ADDR_W      8

// command word fields
`define FPS_CMD_OPC     7:0
`define FPS_CMD_R1      11:8
`define FPS_CMD_CNT_HI  17:14
`define FPS_CMD_CNT_LO  13:12
`define FPS_CMD_R1_ODD  8

// opcodes
`define FPS_OPC_DLEFT   8'h8F
`define FPS_OPC_SRIGHT  8'h8A

// status bits
`define FPS_ST_BUSY     0
`define FPS_ST_DONE     1
`define FPS_ST_CC       3:2
`define FPS_ST_ZERO     4
`define FPS_ST_OVF      5
`define FPS_ST_SIGN     6
`define FPS_ST_SPEC     7
`define FPS_ST_OVFINT   8
`define FPS_ST_BADOP    9

// control bits
`define FPS_CTRL_MASK   0

// condition codes
`define FPS_CC_ZERO     2'h0
`define FPS_CC_NEG      2'h1
`define FPS_CC_POS      2'h2
`define FPS_CC_OVF      2'h3

// datapath figures
`define FPS_NIB         3'h4
`define FPS_CNT_ONE     4'h1
`define FPS_CNT_ZERO    4'h0
`define FPS_WORD_ZERO   32'h0000_0000
`define FPS_NGPR        16

`endif

/* File: fps_pkg.sv */
`include "fps_params.svh"

package fps_pkg;

  typedef enum logic [2:0] {
    FPS_IDLE     = 3'b000,
    FPS_DL_LOW   = 3'b001,
    FPS_DL_HIGH  = 3'b010,
    FPS_DL_LOOP  = 3'b011,
    FPS_SR_FIRST = 3'b100,
    FPS_SR_LOOP  = 3'b101,
    FPS_FINISH   = 3'b110
  } fps_state_e;

  typedef enum logic [2:0] {
    FPS_SEL_NONE   = 3'b000,
    FPS_SEL_CMD    = 3'b001,
    FPS_SEL_STATUS = 3'b010,
    FPS_SEL_CTRL   = 3'b011,
    FPS_SEL_GPR    = 3'b100
  } fps_sel_e;

  typedef logic [`FPS_ADDR_W-1:0] fps_addr_t;
  typedef logic [31:0]            fps_word_t;

  typedef struct packed {
    fps_state_e                  st;
    logic [`FPS_NGPR-1:0][31:0]  general_register;
    logic [3:0]                  r1;
    logic [3:0]                  cnt;
    logic [1:0]                  m;
    logic [31:0]                 low;
    logic [3:0]                  carry;
    logic                        sign;
    logic                        rsign;
    logic                        zero;
    logic                        ovf;
    logic [1:0]                  cc;
    logic                        busy;
    logic                        done;
    logic                        spec;
    logic                        ovf_int;
    logic                        bad_op;
    logic                        mask;
    logic [31:0]                 prdata;
    logic                        pslverr;
  } fps_state_s;

endpackage

/* File: fps_shifter.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fps_shifter
  import fps_pkg::*;
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             SRST,
  // apb slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire fps_pkg::fps_addr_t PADDR,
  input  wire fps_pkg::fps_word_t PWDATA,
  output logic [31:0]           PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // program interruption requests and busy flag
  output logic                  FIXED_OVF_INTR,
  output logic                  SPEC_INTR,
  output logic                  BUSY
);
  import fps_pkg::*;

  fps_state_s r;
  fps_state_s n;

  // register decode, used for read and write
  function automatic fps_sel_e decode(input fps_addr_t a);
    fps_sel_e s;
    s = FPS_SEL_NONE;
    if (a == `FPS_OFF_CMD) begin
      s = FPS_SEL_CMD;
    end else if (a == `FPS_OFF_STATUS) begin
      s = FPS_SEL_STATUS;
    end else if (a == `FPS_OFF_CTRL) begin
      s = FPS_SEL_CTRL;
    end else if (a[7:6] == `FPS_GPR_BASE && a[1:0] == 2'h0) begin
      s = FPS_SEL_GPR;
    end
    return s;
  endfunction

  // one right pass: left by lsh, then arithmetic right 4
  function automatic logic [31:0] right_pass(input logic [31:0] v,
                                             input logic [2:0]  lsh);
    logic [35:0] t;
    logic [35:0] l;
    t = {{4{v[31]}}, v};
    l = t << lsh;
    l = $unsigned($signed(l) >>> `FPS_NIB);
    return l[31:0];
  endfunction

  // condition code from flags
  function automatic logic [1:0] cond(input logic o, input logic z,
                                      input logic s);
    logic [1:0] c;
    if (o) begin
      c = `FPS_CC_OVF;
    end else if (z) begin
      c = `FPS_CC_ZERO;
    end else if (s) begin
      c = `FPS_CC_NEG;
    end else begin
      c = `FPS_CC_POS;
    end
    return c;
  endfunction

  fps_sel_e    sel;
  logic [31:0] stat;
  logic [3:0]  odd;
  logic [35:0] lo36;
  logic [35:0] hi36;
  logic [31:0] res;
  logic        wr_acc;

  assign sel = decode(PADDR);
  assign odd = r.r1 | 4'h1;
  assign wr_acc = PSEL && PENABLE && PWRITE && !r.pslverr;

  always_comb begin
    stat = `FPS_WORD_ZERO;
    stat[`FPS_ST_BUSY]   = r.busy;
    stat[`FPS_ST_DONE]   = r.done;
    stat[`FPS_ST_CC]     = r.cc;
    stat[`FPS_ST_ZERO]   = r.zero;
    stat[`FPS_ST_OVF]    = r.ovf;
    stat[`FPS_ST_SIGN]   = r.rsign;
    stat[`FPS_ST_SPEC]   = r.spec;
    stat[`FPS_ST_OVFINT] = r.ovf_int;
    stat[`FPS_ST_BADOP]  = r.bad_op;
  end

  always_comb begin
    n = r;
    lo36 = 36'h0_0000_0000;
    hi36 = 36'h0_0000_0000;
    res = `FPS_WORD_ZERO;

    // apb setup phase: latch read data and error
    if (PSEL && !PENABLE) begin
      n.prdata = `FPS_WORD_ZERO;
      n.pslverr = 1'b0;
      if (sel == FPS_SEL_CMD) begin
        n.pslverr = PWRITE && r.busy;
      end else if (sel == FPS_SEL_STATUS) begin
        n.prdata = stat;
        n.pslverr = PWRITE;
      end else if (sel == FPS_SEL_CTRL) begin
        n.prdata[`FPS_CTRL_MASK] = r.mask;
      end else if (sel == FPS_SEL_GPR) begin
        n.prdata = r.general_register[PADDR[5:2]];
        n.pslverr = PWRITE && r.busy;
      end else begin
        n.pslverr = 1'b1;
      end
    end

    // apb access phase writes
    if (wr_acc) begin
      if (sel == FPS_SEL_CTRL) begin
        n.mask = PWDATA[`FPS_CTRL_MASK];
      end else if (sel == FPS_SEL_GPR) begin
        n.general_register[PADDR[5:2]] = PWDATA;
      end else if (sel == FPS_SEL_CMD) begin
        n.r1 = PWDATA[`FPS_CMD_R1];
        n.cnt = PWDATA[`FPS_CMD_CNT_HI];
        n.m = PWDATA[`FPS_CMD_CNT_LO];
        n.done = 1'b0;
        n.spec = 1'b0;
        n.ovf_int = 1'b0;
        n.bad_op = 1'b0;
        n.zero = 1'b0;
        n.ovf = 1'b0;
        n.carry = 4'h0;
        if (PWDATA[`FPS_CMD_OPC] == `FPS_OPC_DLEFT) begin
          if (PWDATA[`FPS_CMD_R1_ODD]) begin
            n.spec = 1'b1;
            n.done = 1'b1;
          end else begin
            n.sign = r.general_register[PWDATA[`FPS_CMD_R1]][31];
            n.busy = 1'b1;
            n.st = FPS_DL_LOW;
          end
        end else if (PWDATA[`FPS_CMD_OPC] == `FPS_OPC_SRIGHT) begin
          n.busy = 1'b1;
          n.st = FPS_SR_FIRST;
        end else begin
          n.bad_op = 1'b1;
          n.done = 1'b1;
        end
      end
    end

    case (r.st)
      FPS_IDLE: begin
      end

      // low word, shifted by the two low count bits
      FPS_DL_LOW: begin
        lo36 = {4'h0, r.general_register[odd]} << r.m;
        n.low = lo36[31:0];
        n.general_register[odd] = lo36[31:0];
        n.carry = lo36[35:32];
        n.zero = (lo36[31:0] == `FPS_WORD_ZERO);
        n.st = FPS_DL_HIGH;
      end

      // high word, same amount, carry bits merged in
      FPS_DL_HIGH: begin
        hi36 = ({{5{r.sign}}, r.general_register[r.r1][30:0]} << r.m)
               | {32'h0000_0000, r.carry};
        if (hi36[35:31] != {5{r.sign}}) begin
          n.ovf = 1'b1;
        end
        res = {r.sign, hi36[30:0]};
        n.general_register[r.r1] = res;
        if (res != `FPS_WORD_ZERO) begin
          n.zero = 1'b0;
        end
        n.rsign = r.sign;
        if (r.cnt == `FPS_CNT_ZERO) begin
          n.st = FPS_FINISH;
        end else begin
          n.st = FPS_DL_LOOP;
        end
      end

      // left 4 pass on both words
      FPS_DL_LOOP: begin
        lo36 = {4'h0, r.low} << `FPS_NIB;
        n.low = lo36[31:0];
        hi36 = ({{5{r.sign}}, r.general_register[r.r1][30:0]} << `FPS_NIB)
               | {32'h0000_0000, lo36[35:32]};
        if (hi36[35:31] != {5{r.sign}}) begin
          n.ovf = 1'b1;
        end
        res = {r.sign, hi36[30:0]};
        n.general_register[r.r1] = res;
        n.carry = lo36[35:32];
        n.zero = (lo36[31:0] == `FPS_WORD_ZERO)
                 && (res == `FPS_WORD_ZERO);
        if (r.cnt == `FPS_CNT_ONE) begin
          n.general_register[odd] = lo36[31:0];
          n.cnt = `FPS_CNT_ZERO;
          n.st = FPS_FINISH;
        end else begin
          n.cnt = r.cnt - `FPS_CNT_ONE;
        end
      end

      // right shift, amount 3 or less
      FPS_SR_FIRST: begin
        if (r.m != 2'h0) begin
          res = right_pass(r.general_register[r.r1],
                           `FPS_NIB - {1'b0, r.m});
        end else begin
          res = r.general_register[r.r1];
        end
        n.general_register[r.r1] = res;
        n.zero = (res == `FPS_WORD_ZERO);
        n.rsign = res[31];
        if (r.cnt == `FPS_CNT_ZERO) begin
          n.st = FPS_FINISH;
        end else begin
          n.st = FPS_SR_LOOP;
        end
      end

      // right 4 passes
      FPS_SR_LOOP: begin
        res = right_pass(r.general_register[r.r1], 3'h0);
        n.general_register[r.r1] = res;
        n.zero = (res == `FPS_WORD_ZERO);
        n.rsign = res[31];
        if (r.cnt == `FPS_CNT_ONE) begin
          n.cnt = `FPS_CNT_ZERO;
          n.st = FPS_FINISH;
        end else begin
          n.cnt = r.cnt - `FPS_CNT_ONE;
        end
      end

      // condition code and end
      FPS_FINISH: begin
        n.cc = cond(r.ovf, r.zero, r.rsign);
        n.ovf_int = r.ovf && r.mask;
        n.done = 1'b1;
        n.busy = 1'b0;
        n.st = FPS_IDLE;
      end

      default: begin
        n.st = FPS_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign PRDATA = r.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && r.pslverr;
  assign FIXED_OVF_INTR = r.ovf_int;
  assign SPEC_INTR = r.spec;
  assign BUSY = r.busy;

endmodule

/* File: fps_shifter_chk.sv */
`timescale 1ns/1ps
`include "fps_params.svh"
module fps_shifter_chk
  import fps_pkg::*;
(
  // clock and reset
  input wire logic               CLK,
  input wire logic               SRST,
  // apb
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire fps_pkg::fps_addr_t PADDR,
  input wire fps_pkg::fps_word_t PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  // status
  input wire logic               FIXED_OVF_INTR,
  input wire logic               SPEC_INTR,
  input wire logic               BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic       tk;
  logic       dl;
  logic       sr;
  logic [3:0] hi;
  assign tk = PSEL && PENABLE && PWRITE && PADDR == `FPS_OFF_CMD && !BUSY;
  assign dl = tk && PWDATA[7:0] == `FPS_OPC_DLEFT;
  assign sr = tk && PWDATA[7:0] == `FPS_OPC_SRIGHT;
  assign hi = PWDATA[17:14];
  property p_spec; dl && PWDATA[8] |=> SPEC_INTR && !BUSY; endproperty
  a_spec: assert property (p_spec) else $error("odd field not refused");
  property p_start; dl && !PWDATA[8] |=> BUSY && !SPEC_INTR; endproperty
  a_start: assert property (p_start) else $error("shift did not start");
  property p_dl0; dl && !PWDATA[8] && hi == 4'h0 |=> BUSY[*3] ##1 !BUSY; endproperty
  a_dl0: assert property (p_dl0) else $error("short left length");
  property p_dl1; dl && !PWDATA[8] && hi == 4'h1 |=> BUSY[*4] ##1 !BUSY; endproperty
  a_dl1: assert property (p_dl1) else $error("loop left length");
  property p_sr0; sr && hi == 4'h0 |=> BUSY[*2] ##1 !BUSY; endproperty
  a_sr0: assert property (p_sr0) else $error("short right length");
  property p_sr2; sr && hi == 4'h2 |=> BUSY[*4] ##1 !BUSY; endproperty
  a_sr2: assert property (p_sr2) else $error("loop right length");
  property p_srov; sr |=> !FIXED_OVF_INTR[*6]; endproperty
  a_srov: assert property (p_srov) else $error("right shift overflow");
  property p_ovend; $rose(FIXED_OVF_INTR) |-> $fell(BUSY); endproperty
  a_ovend: assert property (p_ovend) else $error("overflow off end");
  property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unmap; PSEL && PENABLE && PADDR == 8'h0C |-> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  c_dl: cover property (dl);
  c_sr: cover property (sr);
  c_ov: cover property (FIXED_OVF_INTR);
endmodule
bind fps_shifter fps_shifter_chk fps_shifter_chk_inst (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .FIXED_OVF_INTR, .SPEC_INTR, .BUSY);

/* File: fps_seq_model.sv */
`timescale 1ns/1ps
module fps_seq_model
  import fps_pkg::*;
(
  // clock
  input  wire logic               clk,
  // apb master
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output fps_pkg::fps_addr_t      paddr,
  output fps_pkg::fps_word_t      pwdata,
  input  wire logic [31:0]        prdata,
  input  wire logic               pready,
  input  wire logic               pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input fps_addr_t a, input fps_word_t d, output fps_word_t q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: fixed_point_arith_shifter_tb.sv */
`timescale 1ns/1ps
`include "fps_params.svh"
module fixed_point_arith_shifter_tb;
  import fps_pkg::*;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FIXED_OVF_INTR, SPEC_INTR, BUSY;
  fps_addr_t   PADDR;
  fps_word_t   PWDATA;
  logic [31:0] PRDATA;
  fps_word_t   q;
  logic        e;
  int          n_fail = 0;
  int          num_checks = 0;
  always #12.5 CLK = ~CLK;
  fps_shifter fps_shifter_inst (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .FIXED_OVF_INTR, .SPEC_INTR, .BUSY);
  fps_seq_model fps_seq_model_inst (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
  task chk(input fps_word_t got, input fps_word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t word %h not %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task wr(input fps_addr_t a, input fps_word_t d);
    fps_seq_model_inst.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input fps_addr_t a);
    fps_seq_model_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task g(input logic [3:0] r, input fps_word_t v);
    wr({`FPS_GPR_BASE, r, 2'b00}, v);
  endtask
  task gr(input logic [3:0] r, input fps_word_t v);
    rd({`FPS_GPR_BASE, r, 2'b00});
    chk(q, v);
  endtask
  // start a command, poll done, compare the code
  task run(input fps_word_t op, input logic [3:0] r, input logic [3:0] hi, input logic [1:0] m, input logic [1:0] cc);
    int n;
    logic b;
    wr(`FPS_OFF_CMD, op | {14'h0000, hi, m, r, 8'h00});
    n = 0;
    b = 1'b0;
    do begin
      rd(`FPS_OFF_STATUS);
      if (n == 0) b = q[0];
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    chk_bit(b, 1'b1);
    chk_bit(q[1], 1'b1);
    chk({30'h0000_0000, q[3:2]}, {30'h0000_0000, cc});
    chk_bit(BUSY, 1'b0);
  endtask
  task print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    wr(`FPS_OFF_CTRL, 32'h0000_0001);
    rd(`FPS_OFF_CTRL);
    chk(q, 32'h0000_0001);
    // left five across the word boundary
    g(4'h2, 32'h0000_0001);
    g(4'h3, 32'h8000_0003);
    run(`FPS_OPC_DLEFT, 4'h2, 4'h1, 2'h1, `FPS_CC_POS);
    gr(4'h2, 32'h0000_0030);
    gr(4'h3, 32'h0000_0060);
    // bit unlike sign leaves
    g(4'h4, 32'h4000_0000);
    g(4'h5, 32'h0000_0000);
    run(`FPS_OPC_DLEFT, 4'h4, 4'h0, 2'h1, `FPS_CC_OVF);
    chk_bit(FIXED_OVF_INTR, 1'b1);
    gr(4'h4, 32'h0000_0000);
    // zero count on a negative pair
    g(4'h6, 32'hFFFF_FFF0);
    g(4'h7, 32'h1234_5678);
    run(`FPS_OPC_DLEFT, 4'h6, 4'h0, 2'h0, `FPS_CC_NEG);
    gr(4'h6, 32'hFFFF_FFF0);
    gr(4'h7, 32'h1234_5678);
    // odd pair field
    wr(`FPS_OFF_CMD, 32'h0000_018F);
    rd(`FPS_OFF_STATUS);
    chk_bit(q[7], 1'b1);
    chk_bit(SPEC_INTR, 1'b1);
    // unknown opcode is flagged, nothing runs
    wr(`FPS_OFF_CMD, 32'h0000_0255);
    rd(`FPS_OFF_STATUS);
    chk_bit(q[9], 1'b1);
    chk_bit(q[0], 1'b0);
    chk_bit(SPEC_INTR, 1'b0);
    chk_bit(PREADY, 1'b1);
    // right nine with junk upper bits, then right three to zero
    g(4'h8, 32'h8000_0100);
    run(32'h4000_008A, 4'h8, 4'h2, 2'h1, `FPS_CC_NEG);
    gr(4'h8, 32'hFFC0_0000);
    g(4'h9, 32'h0000_0007);
    run(`FPS_OPC_SRIGHT, 4'h9, 4'h0, 2'h3, `FPS_CC_ZERO);
    gr(4'h9, 32'h0000_0000);
    // refused accesses
    rd(8'h0C);
    chk_bit(e, 1'b1);
    wr(`FPS_OFF_STATUS, 32'hFFFF_FFFF);
    chk_bit(e, 1'b1);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    print_verdict;
  end
endmodule
